// [logic/aoc_pkg.sv]
// Constants shared by the ADC gain and offset correction block
// Functional notes
// - Gain 0 to 3.5 dB, 0.5 dB steps
// - Codes scaled as full-scale range shrinks
// - Reset selects 0 dB gain
// - Loop estimates and removes offset up to 10 mV
// - Enabled loop updates and corrects every sample
// - Time constant 1M doubling to 2G, rest reserved
// - Time constant counted in sampling clocks; code counts accepted samples only
// - Hold freezes estimate, keeps applying it
// - Reset leaves correction disabled, samples untouched
// - Time constant field at control bits 5:2
package aoc_pkg;
  // ----------------------------------------
  // Sample path
  // ----------------------------------------
  localparam int DW = 12;
  localparam int FIFO_DEPTH = 8;
  localparam int ACC_W = 44;
  localparam int EST_W = 6;
  // About 10 mV of a 1.5 Vpp range over 4096 codes
  localparam logic signed [DW-1:0] OFS_LIMIT = 12'h01B;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int AW = 12;
  localparam logic [AW-1:0] CTRL_OFS = 12'h000;
  localparam logic [AW-1:0] STAT_OFS = 12'h004;
  localparam logic [AW-1:0] EST_OFS = 12'h008;
  localparam logic [AW-1:0] CNT_OFS = 12'h00C;
  localparam int EN_BIT = 0;
  localparam int HOLD_BIT = 1;
  localparam int TC_LSB = 2;
  localparam int TC_W = 4;
  localparam int GAIN_LSB = 6;
  localparam int GAIN_W = 3;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam int ST_SAT_BIT = 0;
  localparam int ST_CLIP_BIT = 1;
  localparam int ST_RSV_BIT = 2;
  // ----------------------------------------
  // Loop time constant: code 0 is 2^20 accepted samples
  // ----------------------------------------
  localparam logic [EST_W-1:0] TC_BASE_SHIFT = 6'h14;
  localparam logic [TC_W-1:0] TC_MAX_CODE = 4'hB;
  // Gain factors in Q2.14, 0.5 dB apart
  localparam int GF_W = 16;
  localparam int GF_FRAC = 14;
endpackage

// [logic/aoc_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module aoc_fifo #(
  parameter int W = 12,
  parameter int D = 8
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic [W-1:0] in_data, // write data
  input wire logic in_valid, // write request
  output logic in_ready, // room left
  output logic [W-1:0] out_data, // head word
  output logic out_valid, // not empty
  input wire logic out_ready, // reader takes head
  output logic [$clog2(D):0] level // words held
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [PW:0] wp_r;
  logic [PW:0] rp_r;
  logic push;
  logic pop;

  assign level = wp_r - rp_r;
  assign in_ready = (level != D[PW:0]);
  assign out_valid = (wp_r != rp_r);
  assign out_data = mem_r[rp_r[PW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= '0;
    end else if (push) begin
      wp_r <= wp_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_r <= '0;
    end else if (pop) begin
      rp_r <= rp_r + 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < D; i++) begin : g_ent
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_r[i] <= '0;
        end else if (push && wp_r[PW-1:0] == PW'(i)) begin
          mem_r[i] <= in_data;
        end
      end
    end
  endgenerate
endmodule

// [logic/aoc_gain.sv]
// Digital gain stage with saturation
`timescale 1ns/1ps
module aoc_gain (
  input wire logic signed [aoc_pkg::DW-1:0] din, // corrected sample
  input wire logic [aoc_pkg::GAIN_W-1:0] gain_sel, // 0.5 dB steps
  output logic signed [aoc_pkg::DW-1:0] dout, // scaled sample
  output logic sat // clipped this sample
);
  localparam int PW = aoc_pkg::DW + aoc_pkg::GF_W;
  logic signed [aoc_pkg::GF_W-1:0] gf;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] scaled;
  logic signed [PW-1:0] maxv;
  logic signed [PW-1:0] minv;

  // Full scale falls 1.5 to 1 Vpp, so codes grow by the same ratio
  always_comb begin
    case (gain_sel)
      3'h0: gf = 16'h4000;
      3'h1: gf = 16'h43CB;
      3'h2: gf = 16'h47CF;
      3'h3: gf = 16'h4C10;
      3'h4: gf = 16'h5092;
      3'h5: gf = 16'h5558;
      3'h6: gf = 16'h5A67;
      3'h7: gf = 16'h5FC2;
      default: gf = 16'h4000;
    endcase
  end

  assign maxv = PW'(signed'({1'b0, {(aoc_pkg::DW-1){1'b1}}}));
  assign minv = -maxv - PW'(1);
  assign prod = PW'(din) * PW'(gf);
  assign scaled = prod >>> aoc_pkg::GF_FRAC;
  assign sat = (scaled > maxv) || (scaled < minv);
  assign dout = (scaled > maxv) ? maxv[aoc_pkg::DW-1:0] :
                (scaled < minv) ? minv[aoc_pkg::DW-1:0] :
                scaled[aoc_pkg::DW-1:0];
endmodule

// [logic/aoc_top.sv]
// ADC sample post-processing: offset loop, gain, output FIFO, APB regs
`timescale 1ns/1ps
module aoc_top (
  input wire logic pclk, // sampling clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [aoc_pkg::AW-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic [aoc_pkg::DW-1:0] sample_in, // raw twos complement
  input wire logic sample_valid, // raw sample present
  output logic sample_ready, // block takes sample
  output logic [aoc_pkg::DW-1:0] out_data, // corrected sample
  output logic out_valid, // FIFO not empty
  input wire logic out_ready // reader takes sample
);
  localparam int DW = aoc_pkg::DW;
  localparam int AC = aoc_pkg::ACC_W;
  localparam int LW = $clog2(aoc_pkg::FIFO_DEPTH) + 1;

  // ----------------------------------------
  // Control and status storage
  // ----------------------------------------
  logic [aoc_pkg::CTRL_W-1:0] ctrl_r;
  logic [2:0] stat_r;
  logic [2:0] stat_nxt;
  logic [31:0] cnt_r;
  logic [31:0] prdata_r;
  logic signed [AC-1:0] acc_r;
  logic signed [AC-1:0] acc_nxt;

  logic dc_correction_enable;
  logic correction_hold;
  logic [aoc_pkg::TC_W-1:0] loop_time_constant_select;
  logic [aoc_pkg::GAIN_W-1:0] gain_sel;

  assign dc_correction_enable = ctrl_r[aoc_pkg::EN_BIT];
  assign correction_hold = ctrl_r[aoc_pkg::HOLD_BIT];
  assign loop_time_constant_select =
    ctrl_r[aoc_pkg::TC_LSB +: aoc_pkg::TC_W];
  assign gain_sel = ctrl_r[aoc_pkg::GAIN_LSB +: aoc_pkg::GAIN_W];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic setup_ph;
  logic acc_ph;
  logic wr_en;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_est;
  logic hit_cnt;
  logic mapped;

  assign setup_ph = psel & ~penable;
  assign acc_ph = psel & penable;
  assign hit_ctrl = (paddr == aoc_pkg::CTRL_OFS);
  assign hit_stat = (paddr == aoc_pkg::STAT_OFS);
  assign hit_est = (paddr == aoc_pkg::EST_OFS);
  assign hit_cnt = (paddr == aoc_pkg::CNT_OFS);
  assign mapped = hit_ctrl | hit_stat | hit_est | hit_cnt;
  // Read data is captured in setup, so access never needs a wait state
  assign pready = acc_ph;
  assign pslverr = acc_ph & ~mapped;
  assign prdata = prdata_r;
  assign wr_en = acc_ph & pwrite & mapped;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= aoc_pkg::CTRL_RST;
    end else if (wr_en && hit_ctrl) begin
      ctrl_r <= pwdata[aoc_pkg::CTRL_W-1:0];
    end
  end

  // ----------------------------------------
  // Loop time constant
  // ----------------------------------------
  logic [aoc_pkg::TC_W-1:0] tc_eff;
  logic [aoc_pkg::EST_W-1:0] shift;
  logic tc_reserved;

  // Reserved codes run at the slowest legal constant and are flagged
  assign tc_reserved = (loop_time_constant_select > aoc_pkg::TC_MAX_CODE);
  assign tc_eff = tc_reserved ? aoc_pkg::TC_MAX_CODE
                              : loop_time_constant_select;
  // One shift step per code doubles the constant; counted in accepted samples
  assign shift = aoc_pkg::TC_BASE_SHIFT +
                 aoc_pkg::EST_W'(tc_eff);

  // ----------------------------------------
  // Offset estimate
  // ----------------------------------------
  logic signed [AC-1:0] x_ext;
  logic signed [AC-1:0] est_full;
  logic signed [AC-1:0] lim_hi;
  logic signed [AC-1:0] lim_lo;
  logic signed [DW-1:0] est;
  logic est_clip;
  logic take;

  assign x_ext = AC'(signed'(sample_in));
  assign est_full = acc_r >>> shift;
  assign lim_hi = AC'(aoc_pkg::OFS_LIMIT);
  assign lim_lo = -lim_hi;
  // Beyond the correctable range the removal is capped, not wrapped
  assign est_clip = (est_full > lim_hi) || (est_full < lim_lo);
  always_comb begin
    if (est_full > lim_hi) begin
      est = aoc_pkg::OFS_LIMIT;
    end else if (est_full < lim_lo) begin
      est = -aoc_pkg::OFS_LIMIT;
    end else begin
      est = est_full[DW-1:0];
    end
  end

  // Leaky average: acc settles to offset times 2^shift
  always_comb begin
    acc_nxt = acc_r;
    if (!dc_correction_enable) begin
      acc_nxt = '0;
    end else if (take && !correction_hold) begin
      acc_nxt = acc_r + x_ext - est_full;
    end
  end

  // Hold keeps acc untouched, so release resumes from it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // ----------------------------------------
  // Sample path
  // ----------------------------------------
  logic signed [DW:0] diff;
  logic signed [DW-1:0] corr;
  logic signed [DW-1:0] gained;
  logic gain_sat;
  logic fifo_in_ready;
  logic [LW-1:0] fifo_level;

  assign diff = {sample_in[DW-1], sample_in} - {est[DW-1], est};
  always_comb begin
    if (!dc_correction_enable) begin
      corr = sample_in;
    end else if (diff[DW] != diff[DW-1]) begin
      corr = {diff[DW], {(DW-1){~diff[DW]}}};
    end else begin
      corr = diff[DW-1:0];
    end
  end

  aoc_gain u_gain (
    .din(corr),
    .gain_sel(gain_sel),
    .dout(gained),
    .sat(gain_sat)
  );

  // A full FIFO stalls the source, never drops a sample
  assign sample_ready = fifo_in_ready;
  assign take = sample_valid & fifo_in_ready;

  aoc_fifo #(
    .W(DW),
    .D(aoc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_data(gained),
    .in_valid(sample_valid),
    .in_ready(fifo_in_ready),
    .out_data(out_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .level(fifo_level)
  );

  // ----------------------------------------
  // Sticky status, write one to clear
  // ----------------------------------------
  logic [2:0] stat_evt;
  logic [2:0] stat_clr;

  assign stat_evt[aoc_pkg::ST_SAT_BIT] = take & gain_sat;
  assign stat_evt[aoc_pkg::ST_CLIP_BIT] =
    take & dc_correction_enable & est_clip;
  assign stat_evt[aoc_pkg::ST_RSV_BIT] = tc_reserved;
  assign stat_clr = (wr_en && hit_stat) ? pwdata[2:0] : 3'h0;
  // An event in the clearing cycle survives the clear
  assign stat_nxt = (stat_r & ~stat_clr) | stat_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ----------------------------------------
  // Accepted sample counter, write clears
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (wr_en && hit_cnt) begin
      cnt_r <= {31'h0000_0000, take};
    end else if (take) begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Read data, captured in setup phase
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= '0;
      if (hit_ctrl) begin
        prdata_r <= {23'h00_0000, ctrl_r};
      end else if (hit_stat) begin
        prdata_r <= {20'h0_0000, 4'(fifo_level), 5'h00, stat_r};
      end else if (hit_est) begin
        prdata_r <= 32'(est);
      end else if (hit_cnt) begin
        prdata_r <= cnt_r;
      end
    end
  end
endmodule

// [tb/aoc_top_sva.sv]
// Port-level assertions for the gain and offset correction top
`timescale 1ns/1ps
module aoc_top_chk (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [aoc_pkg::AW-1:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [aoc_pkg::DW-1:0] sample_in, // raw sample
  input wire logic sample_valid, // raw valid
  input wire logic sample_ready, // raw ready
  input wire logic [aoc_pkg::DW-1:0] out_data, // corrected sample
  input wire logic out_valid, // out valid
  input wire logic out_ready // out ready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [8:0] ctrl_r;
  logic acc_w;
  assign acc_w = psel && penable;
  // Shadow of the control word, so plain passthrough can be recognised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_r <= 9'h000;
    else if (acc_w && pwrite && paddr == aoc_pkg::CTRL_OFS) ctrl_r <= pwdata[8:0];
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence take_s;
    sample_valid && sample_ready && !out_ready;
  endsequence
  sequence fill_s;
    (!out_valid && sample_valid && sample_ready && !out_ready) ##1 take_s [*7];
  endsequence
  apb_ready_a: assert property (pready == acc_w) else $error("pready not tied to access");
  unmapped_err_a: assert property (acc_w && paddr[11:4] != 0 |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc_w && paddr[11:4] == 0 && paddr[1:0] == 0 |-> !pslverr)
    else $error("mapped access refused");
  first_out_a: assert property (sample_valid && sample_ready && !out_valid |=> out_valid)
    else $error("output late after take");
  stall_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output changed while stalled");
  fill_full_a: assert property (fill_s |=> !sample_ready) else $error("buffer not full at 8");
  full_only_a: assert property (!sample_ready |-> out_valid) else $error("refused while empty");
  pass_thru_a: assert property (
    sample_valid && sample_ready && !out_valid && ctrl_r == 9'h000 |=> out_data == $past(sample_in))
    else $error("sample altered at default settings");
endmodule

// [tb/tb_aoc_top.sv]
// Self-checking bench for the gain and offset correction top
`timescale 1ns/1ps
module tb_aoc_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sample_valid = 1'b0, out_ready = 1'b0, pready, pslverr, sample_ready, out_valid, err;
  logic [11:0] paddr = 12'h000, sample_in = 12'h000, out_data;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, e;
  int err_total = 0, checks = 0, shift = 20;
  longint acc = 0;
  logic en = 1'b0, hold = 1'b0;
  logic [15:0] gf [8] = '{16'h4000, 16'h43CB, 16'h47CF, 16'h4C10,
                          16'h5092, 16'h5558, 16'h5A67, 16'h5FC2};
  aoc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sample_in, .sample_valid, .sample_ready, .out_data, .out_valid, .out_ready);
  always #50 pclk = ~pclk;
  // ----------------------------------------
  // Bus and stream tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Idle edge after each transfer so psel is never driven twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_total++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic step(input logic [11:0] x);
    if (en && !hold) acc += longint'($signed(x)) - (acc >>> shift);
  endtask
  function automatic logic [31:0] est();
    longint v;
    v = acc >>> shift;
    if (v > 27) v = 27;
    if (v < -27) v = -27;
    return v[31:0];
  endfunction
  task automatic push(input logic [11:0] x);
    sample_in <= x;
    sample_valid <= 1'b1;
    @(posedge pclk);
    step(x);
    sample_valid <= 1'b0;
  endtask
  task automatic pop(input logic [11:0] x, input string nm);
    int n;
    n = 0;
    out_ready <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (out_valid !== 1'b1 && n < 20);
    if (out_valid !== 1'b1) err_total++;
    chk(nm, 32'(out_data), 32'(x));
    out_ready <= 1'b0;
  endtask
  task automatic stream(input logic [11:0] x, input int n);
    sample_in <= x;
    sample_valid <= 1'b1;
    out_ready <= 1'b1;
    repeat (n) begin
      @(posedge pclk);
      step(x);
    end
    sample_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    out_ready <= 1'b0;
  endtask
  task automatic rd_est(input string nm);
    apb(1'b0, aoc_pkg::EST_OFS, 32'h0000_0000);
    chk(nm, q, est());
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    apb(1'b0, aoc_pkg::CTRL_OFS, 32'h0000_0000);
    chk("ctrl reset", q, 32'h0000_0000);
    rd_est("est reset");
    push(12'h123);
    pop(12'h123, "passthru");
  endtask
  task automatic t_gain;
    for (int g = 0; g < 8; g++) begin
      apb(1'b1, aoc_pkg::CTRL_OFS, 32'(g) << 6);
      push(12'h400);
      pop(gf[g][15:4], "gain");
    end
    push(12'h800);
    pop(12'h800, "gain sat");
    apb(1'b0, aoc_pkg::STAT_OFS, 32'h0000_0000);
    chk("sat flag", 32'(q[0]), 32'h0000_0001);
    apb(1'b1, aoc_pkg::CTRL_OFS, 32'h0000_0000);
  endtask
  task automatic t_loop;
    en = 1'b1;
    apb(1'b1, aoc_pkg::CTRL_OFS, 32'h0000_0001);
    stream(12'h7FF, 1100);
    rd_est("est run");
    hold = 1'b1;
    apb(1'b1, aoc_pkg::CTRL_OFS, 32'h0000_0003);
    stream(12'h7FF, 600);
    rd_est("est held");
    e = est();
    push(12'h100);
    pop(12'h100 - e[11:0], "held corr");
    hold = 1'b0;
    apb(1'b1, aoc_pkg::CTRL_OFS, 32'h0000_0001);
    stream(12'h7FF, 600);
    rd_est("est resumed");
    en = 1'b0;
    acc = 0;
    apb(1'b1, aoc_pkg::CTRL_OFS, 32'h0000_0000);
    rd_est("est cleared");
    en = 1'b1;
    shift = 21;
    apb(1'b1, aoc_pkg::CTRL_OFS, 32'h0000_0005);
    stream(12'h7FF, 1100);
    rd_est("est tc1");
    apb(1'b1, aoc_pkg::CTRL_OFS, 32'h0000_0031);
    apb(1'b0, aoc_pkg::CTRL_OFS, 32'h0000_0000);
    chk("ctrl tc field", q, 32'h0000_0031);
    apb(1'b0, aoc_pkg::STAT_OFS, 32'h0000_0000);
    chk("tc reserved", 32'(q[2]), 32'h0000_0001);
    en = 1'b0;
    apb(1'b1, aoc_pkg::CTRL_OFS, 32'h0000_0000);
  endtask
  task automatic t_fifo;
    sample_valid <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      sample_in <= 12'(i + 1);
      @(posedge pclk);
    end
    sample_valid <= 1'b0;
    @(posedge pclk);
    chk("full", 32'(sample_ready), 32'h0000_0000);
    out_ready <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      chk("fifo order", 32'(out_data), 32'(i + 1));
    end
    out_ready <= 1'b0;
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("slverr", 32'(err), 32'h0000_0001);
    chk("unmapped data", q, 32'h0000_0000);
    apb(1'b1, 12'h014, 32'hFFFF_FFFF);
    chk("slverr wr", 32'(err), 32'h0000_0001);
    apb(1'b1, aoc_pkg::CNT_OFS, 32'h0000_0000);
    push(12'h055);
    pop(12'h055, "cnt sample");
    apb(1'b0, aoc_pkg::CNT_OFS, 32'h0000_0000);
    chk("cnt", q, 32'h0000_0001);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_gain;
    t_loop;
    t_fifo;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    end_of_test;
  end
endmodule
bind aoc_top aoc_top_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .sample_in, .sample_valid, .sample_ready, .out_data, .out_valid,
  .out_ready);
